// ==== common/ladder_consts.svh ====
// Constants for the ladder transfer and control executor
`ifndef LADDER_CONSTS_SVH
`define LADDER_CONSTS_SVH
`define OP_NONE_CODE 8'h00
`define OP_EVENT_COUNTER_CODE 8'hF0
`define OP_RAIL_OPEN_CODE 8'hF1
`define OP_RAIL_CLOSE_CODE 8'hF2
`define OP_SKIP_BEGIN_CODE 8'hF3
`define OP_SKIP_END_CODE 8'hF4
`define OP_PROGRAM_END_CODE 8'hF5
`define FN_WORD_COPY 8'h12
`define FN_PAIR_COPY 8'h13
`define FN_COMPLEMENT_COPY 8'h14
`define FN_OPERAND_SWAP 8'h16
`define FN_TABLE_FILL 8'h18
`define FN_TABLE_COPY 8'h19
`define FN_TABLE_COMPLEMENT_COPY 8'hE5
`define FN_INDEXED_READ 8'h5A
`define FN_INDEXED_WRITE 8'h5B
`define STEPS_ONE 3'h1
`define STEPS_COUNTER 3'h2
`define STEPS_TRANSFER 3'h3
`define STEPS_INDEXED 3'h5
`define LEN_SINGLE 1
`define LEN_PAIR 2
`define ST_IDLE_CODE 4'h1
`define ST_FETCH_CODE 4'h2
`define ST_STORE_CODE 4'h4
`define ST_SWAP_CODE 4'h8
`endif

// ==== common/ladder_pkg.sv ====
// Types shared by the ladder transfer and control executor
`default_nettype none
`include "ladder_consts.svh"
package ladder_pkg;
  typedef enum logic [7:0] {
    OP_NONE = `OP_NONE_CODE,
    OP_EVENT_COUNTER_INSTR = `OP_EVENT_COUNTER_CODE,
    OP_RAIL_GATE_OPEN = `OP_RAIL_OPEN_CODE,
    OP_RAIL_GATE_CLOSE = `OP_RAIL_CLOSE_CODE,
    OP_SKIP_REGION_BEGIN = `OP_SKIP_BEGIN_CODE,
    OP_SKIP_REGION_END = `OP_SKIP_END_CODE,
    OP_PROGRAM_END = `OP_PROGRAM_END_CODE,
    OP_WORD_COPY = `FN_WORD_COPY,
    OP_PAIR_COPY = `FN_PAIR_COPY,
    OP_COMPLEMENT_COPY = `FN_COMPLEMENT_COPY,
    OP_OPERAND_SWAP = `FN_OPERAND_SWAP,
    OP_TABLE_FILL = `FN_TABLE_FILL,
    OP_TABLE_COPY = `FN_TABLE_COPY,
    OP_TABLE_COMPLEMENT_COPY = `FN_TABLE_COMPLEMENT_COPY,
    OP_INDEXED_READ = `FN_INDEXED_READ,
    OP_INDEXED_WRITE = `FN_INDEXED_WRITE
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE = `ST_IDLE_CODE,
    ST_FETCH = `ST_FETCH_CODE,
    ST_STORE = `ST_STORE_CODE,
    ST_SWAP = `ST_SWAP_CODE
  } state_t;

  function automatic logic [2:0] steps_of(input op_t op);
    case (op)
      OP_EVENT_COUNTER_INSTR: steps_of = `STEPS_COUNTER;
      OP_INDEXED_READ, OP_INDEXED_WRITE: steps_of = `STEPS_INDEXED;
      OP_WORD_COPY, OP_PAIR_COPY, OP_COMPLEMENT_COPY, OP_OPERAND_SWAP,
      OP_TABLE_FILL, OP_TABLE_COPY, OP_TABLE_COMPLEMENT_COPY:
        steps_of = `STEPS_TRANSFER;
      default: steps_of = `STEPS_ONE;
    endcase
  endfunction : steps_of
endpackage : ladder_pkg
`default_nettype wire

// ==== tb/test_ladder_transfer_control_exec.sv ====
// Self-checking bench for the ladder transfer and control executor
`timescale 1ns/1ps
`default_nettype none
module test_ladder_transfer_control_exec;
  import ladder_pkg::*;
  localparam logic [3:0] F_AC = 4'h8;
  localparam logic [3:0] F_BC = 4'h4;
  localparam logic [3:0] F_RG = 4'h2;
  localparam logic [3:0] F_EN = 4'h1;
  logic sys_clk, nrst, start, rung_in, enable_in, a_const, b_const, host_we;
  op_t op;
  logic [15:0] opnd_a, opnd_b, opnd_c, host_wdata, host_rdata, rv;
  logic [7:0] table_len;
  logic [9:0] host_addr;
  logic busy, done, count_out, rail_on, skip_on, end_hit, ended;
  logic [2:0] step_len;
  int failures, comparisons, lat;

  ladder_transfer_control_exec uut (
    .sys_clk(sys_clk), .nrst(nrst), .start(start), .op(op),
    .rung_in(rung_in), .enable_in(enable_in), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .opnd_c(opnd_c), .a_const(a_const), .b_const(b_const),
    .table_len(table_len), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .busy(busy),
    .done(done), .count_out(count_out), .rail_on(rail_on),
    .skip_on(skip_on), .end_hit(end_hit), .step_len(step_len)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    host_we = 1'b1;
    host_addr = a;
    host_wdata = d;
    tick();
    host_we = 1'b0;
    tick();
  endtask : wr

  // Two edges: the idle read path answers one cycle late
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    host_addr = a;
    tick();
    tick();
    d = host_rdata;
  endtask : rd

  // Operands stay put until done so nothing shifts under the executor
  task automatic run(input op_t o, input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] c, input logic [7:0] n, input logic [3:0] f);
    // One idle edge first, so start is never lowered and raised at once
    tick();
    op = o;
    opnd_a = a;
    opnd_b = b;
    opnd_c = c;
    table_len = n;
    {a_const, b_const, rung_in, enable_in} = f;
    start = 1'b1;
    tick();
    start = 1'b0;
    lat = 1;
    ended = end_hit;
    while (done !== 1'b1 && lat < 600) begin
      check(busy, 1'b1);
      tick();
      lat++;
      ended = ended | end_hit;
    end
    check(done, 1'b1);
    check(busy, 1'b0);
  endtask : run

  task automatic test_copies();
    wr(10'h00A, 16'h1234);
    run(OP_WORD_COPY, 16'h000A, 16'h0014, 16'h0000, 8'h00, F_RG);
    check(16'(lat), 16'h0003);
    check(step_len, 3'h3);
    check(ended, 1'b0);
    rd(10'h014, rv);
    check(rv, 16'h1234);
    run(OP_WORD_COPY, 16'hBEEF, 16'h0015, 16'h0000, 8'h00, F_RG | F_AC);
    rd(10'h015, rv);
    check(rv, 16'hBEEF);
    wr(10'h01E, 16'h1111);
    wr(10'h01F, 16'h2222);
    run(OP_PAIR_COPY, 16'h001E, 16'h0028, 16'h0000, 8'h00, F_RG);
    check(step_len, 3'h3);
    rd(10'h028, rv);
    check(rv, 16'h1111);
    rd(10'h029, rv);
    check(rv, 16'h2222);
    wr(10'h032, 16'h00FF);
    run(OP_COMPLEMENT_COPY, 16'h0032, 16'h0033, 16'h0000, 8'h00, F_RG);
    rd(10'h033, rv);
    check(rv, 16'hFF00);
    run(OP_COMPLEMENT_COPY, 16'h0F0F, 16'h0034, 16'h0000, 8'h00, F_RG | F_AC);
    rd(10'h034, rv);
    check(rv, 16'hF0F0);
    wr(10'h050, 16'hAAAA);
    wr(10'h051, 16'h5555);
    run(OP_OPERAND_SWAP, 16'h0050, 16'h0051, 16'h0000, 8'h00, F_RG);
    rd(10'h050, rv);
    check(rv, 16'h5555);
    rd(10'h051, rv);
    check(rv, 16'hAAAA);
  endtask : test_copies

  task automatic test_tables();
    for (int i = 0; i < 3; i++) wr(10'(16'h3C + i), 16'(i + 1));
    run(OP_TABLE_COMPLEMENT_COPY, 16'h003C, 16'h0046, 16'h0000, 8'h03, F_RG);
    check(16'(lat), 16'h0007);
    for (int i = 0; i < 4; i++) begin
      rd(10'(16'h46 + i), rv);
      check(rv, (i < 3) ? ~16'(i + 1) : 16'h0000);
    end
    run(OP_TABLE_FILL, 16'h7777, 16'h005A, 16'h0000, 8'h04, F_RG | F_AC);
    for (int i = 0; i < 5; i++) begin
      rd(10'(16'h5A + i), rv);
      check(rv, (i < 4) ? 16'h7777 : 16'h0000);
    end
    run(OP_TABLE_COPY, 16'h003C, 16'h0064, 16'h0000, 8'h03, F_RG);
    for (int i = 0; i < 4; i++) begin
      rd(10'(16'h64 + i), rv);
      check(rv, (i < 3) ? 16'(i + 1) : 16'h0000);
    end
  endtask : test_tables

  task automatic test_indexed();
    run(OP_INDEXED_READ, 16'h003C, 16'h0002, 16'h006E, 8'h03, F_RG | F_BC);
    check(step_len, 3'h5);
    rd(10'h06E, rv);
    check(rv, 16'h0003);
    wr(10'h070, 16'h0001);
    run(OP_INDEXED_READ, 16'h003C, 16'h0070, 16'h0071, 8'h03, F_RG);
    rd(10'h071, rv);
    check(rv, 16'h0002);
    run(OP_INDEXED_READ, 16'h003C, 16'h0003, 16'h006F, 8'h03, F_RG | F_BC);
    rd(10'h06F, rv);
    check(rv, 16'h0000);
    run(OP_INDEXED_WRITE, 16'h4242, 16'h0001, 16'h0078, 8'h02,
        F_RG | F_AC | F_BC);
    run(OP_INDEXED_WRITE, 16'h4242, 16'h0002, 16'h0078, 8'h02,
        F_RG | F_AC | F_BC);
    for (int i = 0; i < 3; i++) begin
      rd(10'(16'h78 + i), rv);
      check(rv, (i == 1) ? 16'h4242 : 16'h0000);
    end
    run(OP_INDEXED_WRITE, 16'h000A, 16'h0000, 16'h007C, 8'h02, F_RG | F_BC);
    rd(10'h07C, rv);
    check(rv, 16'h1234);
  endtask : test_indexed

  task automatic test_counter();
    logic [6:0] pat;
    logic prev;
    int cnt;
    pat = 7'h56;
    prev = 1'b0;
    cnt = 0;
    for (int i = 0; i < 7; i++) begin
      run(OP_EVENT_COUNTER_INSTR, 16'h0003, 16'h0082, 16'h0000, 8'h00,
          F_AC | F_EN | (pat[i] ? F_RG : 4'h0));
      if (pat[i] && !prev && cnt < 3) cnt++;
      prev = pat[i];
      check(count_out, cnt >= 3);
    end
    check(step_len, 3'h2);
    rd(10'h082, rv);
    check(rv, 16'h0003);
    run(OP_EVENT_COUNTER_INSTR, 16'h0003, 16'h0082, 16'h0000, 8'h00,
        F_AC | F_RG);
    check(count_out, 1'b0);
    wr(10'h08A, 16'h0001);
    run(OP_EVENT_COUNTER_INSTR, 16'h008A, 16'h0083, 16'h0000, 8'h00,
        F_EN | F_RG);
    check(count_out, 1'b1);
  endtask : test_counter

  task automatic test_control();
    run(OP_RAIL_GATE_OPEN, 16'h0000, 16'h0000, 16'h0000, 8'h00, F_RG);
    check(rail_on, 1'b1);
    run(OP_RAIL_GATE_OPEN, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    check(rail_on, 1'b0);
    check(step_len, 3'h1);
    run(OP_WORD_COPY, 16'h9999, 16'h008C, 16'h0000, 8'h00, F_RG | F_AC);
    rd(10'h08C, rv);
    check(rv, 16'h0000);
    run(OP_RAIL_GATE_CLOSE, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    check(rail_on, 1'b1);
    run(OP_SKIP_REGION_BEGIN, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    check(skip_on, 1'b0);
    run(OP_SKIP_REGION_BEGIN, 16'h0000, 16'h0000, 16'h0000, 8'h00, F_RG);
    check(skip_on, 1'b1);
    run(OP_WORD_COPY, 16'h9999, 16'h0096, 16'h0000, 8'h00, F_RG | F_AC);
    rd(10'h096, rv);
    check(rv, 16'h0000);
    run(OP_SKIP_REGION_END, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    check(skip_on, 1'b0);
    run(OP_WORD_COPY, 16'h9999, 16'h0096, 16'h0000, 8'h00, F_RG | F_AC);
    rd(10'h096, rv);
    check(rv, 16'h9999);
    run(OP_RAIL_GATE_OPEN, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    run(OP_PROGRAM_END, 16'h0000, 16'h0000, 16'h0000, 8'h00, 4'h0);
    check(ended, 1'b1);
    check(step_len, 3'h1);
    check(rail_on, 1'b1);
  endtask : test_control

  // Generous span: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    comparisons = 0;
    nrst = 1'b0;
    start = 1'b0;
    op = OP_NONE;
    {rung_in, enable_in, a_const, b_const, host_we} = 5'h00;
    {opnd_a, opnd_b, opnd_c, host_wdata} = 64'h0;
    table_len = 8'h00;
    host_addr = 10'h000;
    repeat (5) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    check(rail_on, 1'b1);
    check({busy, done, skip_on, count_out}, 4'h0);
    test_copies();
    test_tables();
    test_indexed();
    test_counter();
    test_control();
    complete_run();
  end
endmodule : test_ladder_transfer_control_exec
`default_nettype wire

// ==== verilog/ladder_transfer_control_exec.sv ====
// Executor for counter, rail gate, skip region, end and transfer ops
// Function
// - Counter adds one per rising count input while enable is on; two steps.
// - Counter output turns on once the count reaches the preset operand.
// - Open gate with input off forces rail off until the closing gate, the end instruction or an open gate with input on.
// - Skip begin with input on skips everything except the end instruction up to skip end.
// - End instruction, one step, terminates main or sub-program.
// - Function 018 copies one source word to destination; three steps.
// - Function 019 copies a register pair, upper word at next address.
// - Function 020 writes complement; table form complements n registers.
// - Function 022 swaps the contents of its two operands.
// - Function 024 writes one source value into n registers.
// - Function 025 copies n registers from source to destination.
// - Function 090, five steps, reads table entry at index into destination.
// - Function 091 writes source value into table entry at index.
// - Operands are a register or a constant supplied with the instruction.
`timescale 1ns/1ps
`default_nettype none
`include "ladder_consts.svh"
module ladder_transfer_control_exec #(
  parameter int AW = 10,
  parameter int DW = 16,
  parameter int NW = 8,
  parameter int SLOT_W = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire ladder_pkg::op_t op,
  input wire logic rung_in,
  input wire logic enable_in,
  input wire logic [DW-1:0] opnd_a,
  input wire logic [DW-1:0] opnd_b,
  input wire logic [DW-1:0] opnd_c,
  input wire logic a_const,
  input wire logic b_const,
  input wire logic [NW-1:0] table_len,
  input wire logic host_we,
  input wire logic [AW-1:0] host_addr,
  input wire logic [DW-1:0] host_wdata,
  output logic [DW-1:0] host_rdata,
  output logic busy,
  output logic done,
  output logic count_out,
  output logic rail_on,
  output logic skip_on,
  output logic end_hit,
  output logic [2:0] step_len
);
  import ladder_pkg::*;

  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [AW-1:0] src_q, src_d, dst_q, dst_d;
  logic [NW-1:0] len_q, len_d, i_q, i_d;
  logic [DW-1:0] tmp_q, tmp_d, aval_q, aval_d, hrd_q, hrd_d;
  logic step_src_q, step_src_d, inv_q, inv_d, csrc_q, csrc_d;
  logic cin_q, cin_d, en_q, en_d, done_q, done_d, busy_q, busy_d;
  logic cq_q, cq_d, rail_q, rail_d, skip_q, skip_d, end_q, end_d;
  logic [2:0] step_q, step_d;
  logic [2**SLOT_W-1:0] edge_q, edge_d;
  logic we;
  logic [AW-1:0] waddr, raddr0, raddr1;
  logic [DW-1:0] wdata, rd0, rd1, idx, newc;
  logic pow;

  // Host port shares the memory only while idle, so it never races an op
  reg_mem #(.AW(AW), .DW(DW)) u_mem (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .we(we),
    .waddr(waddr),
    .wdata(wdata),
    .raddr0(raddr0),
    .rdata0(rd0),
    .raddr1(raddr1),
    .rdata1(rd1)
  );

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    src_d = src_q;
    dst_d = dst_q;
    len_d = len_q;
    i_d = i_q;
    tmp_d = tmp_q;
    aval_d = aval_q;
    hrd_d = hrd_q;
    step_src_d = step_src_q;
    inv_d = inv_q;
    csrc_d = csrc_q;
    cin_d = cin_q;
    en_d = en_q;
    cq_d = cq_q;
    rail_d = rail_q;
    skip_d = skip_q;
    edge_d = edge_q;
    step_d = step_q;
    done_d = 1'b0;
    end_d = 1'b0;
    we = 1'b0;
    waddr = host_addr;
    wdata = host_wdata;
    raddr0 = host_addr;
    newc = '0;
    pow = rung_in & rail_q & ~skip_q;
    // Counter reads its preset, indexed ops read their index
    raddr1 = (op == OP_EVENT_COUNTER_INSTR) ? opnd_a[AW-1:0]
                                            : opnd_b[AW-1:0];
    idx = b_const ? opnd_b : rd1;
    case (state_q)
      ST_IDLE: begin
        hrd_d = rd0;
        we = host_we & ~start;
        if (start) begin
          op_d = op;
          step_d = steps_of(op);
          i_d = '0;
          src_d = opnd_a[AW-1:0];
          dst_d = opnd_b[AW-1:0];
          len_d = NW'(`LEN_SINGLE);
          step_src_d = 1'b1;
          inv_d = 1'b0;
          csrc_d = a_const;
          aval_d = opnd_a;
          done_d = 1'b1;
          case (op)
            OP_RAIL_GATE_OPEN: if (!skip_q) rail_d = rung_in;
            OP_RAIL_GATE_CLOSE: if (!skip_q) rail_d = 1'b1;
            OP_SKIP_REGION_BEGIN: if (!skip_q) skip_d = rung_in & rail_q;
            OP_SKIP_REGION_END: skip_d = 1'b0;
            OP_PROGRAM_END: begin
              end_d = 1'b1;
              rail_d = 1'b1;
              skip_d = 1'b0;
            end
            OP_EVENT_COUNTER_INSTR: begin
              if (!skip_q) begin
                aval_d = a_const ? opnd_a : rd1;
                cin_d = pow;
                en_d = enable_in & rail_q;
                state_d = ST_STORE;
                done_d = 1'b0;
              end
            end
            OP_WORD_COPY, OP_PAIR_COPY, OP_COMPLEMENT_COPY, OP_OPERAND_SWAP,
            OP_TABLE_FILL, OP_TABLE_COPY, OP_TABLE_COMPLEMENT_COPY,
            OP_INDEXED_READ, OP_INDEXED_WRITE: begin
              case (op)
                OP_PAIR_COPY: len_d = NW'(`LEN_PAIR);
                OP_COMPLEMENT_COPY: inv_d = 1'b1;
                OP_TABLE_COMPLEMENT_COPY: begin
                  inv_d = 1'b1;
                  len_d = table_len;
                end
                OP_TABLE_FILL: begin
                  len_d = table_len;
                  step_src_d = 1'b0;
                end
                OP_TABLE_COPY: len_d = table_len;
                OP_OPERAND_SWAP: csrc_d = 1'b0;
                OP_INDEXED_READ: begin
                  src_d = AW'(opnd_a[AW-1:0] + idx[AW-1:0]);
                  dst_d = opnd_c[AW-1:0];
                  csrc_d = 1'b0;
                end
                OP_INDEXED_WRITE: begin
                  dst_d = AW'(opnd_c[AW-1:0] + idx[AW-1:0]);
                end
                default: len_d = NW'(`LEN_SINGLE);
              endcase
              // Out-of-range index or empty table finishes with no access
              if (pow && len_d != '0 &&
                  !((op == OP_INDEXED_READ || op == OP_INDEXED_WRITE) &&
                    idx >= DW'(table_len))) begin
                state_d = ST_FETCH;
                done_d = 1'b0;
              end
            end
            default: done_d = 1'b1;
          endcase
        end
      end
      ST_FETCH: begin
        raddr0 = step_src_q ? AW'(src_q + AW'(i_q)) : src_q;
        tmp_d = csrc_q ? aval_q : rd0;
        state_d = ST_STORE;
      end
      ST_STORE: begin
        raddr0 = AW'(dst_q + AW'(i_q));
        waddr = raddr0;
        we = 1'b1;
        if (op_q == OP_EVENT_COUNTER_INSTR) begin
          // Count holds at the preset; enable off clears the count
          if (!en_q) newc = '0;
          else if (cin_q && !edge_q[dst_q[SLOT_W-1:0]] && rd0 < aval_q)
            newc = DW'(rd0 + 1'b1);
          else newc = rd0;
          edge_d[dst_q[SLOT_W-1:0]] = cin_q;
          cq_d = en_q && newc >= aval_q;
          wdata = newc;
          state_d = ST_IDLE;
          done_d = 1'b1;
        end else if (op_q == OP_OPERAND_SWAP) begin
          wdata = tmp_q;
          tmp_d = rd0;
          state_d = ST_SWAP;
        end else begin
          wdata = inv_q ? ~tmp_q : tmp_q;
          if (i_q == NW'(len_q - 1'b1)) begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end else begin
            i_d = NW'(i_q + 1'b1);
            state_d = ST_FETCH;
          end
        end
      end
      ST_SWAP: begin
        we = 1'b1;
        waddr = src_q;
        wdata = tmp_q;
        state_d = ST_IDLE;
        done_d = 1'b1;
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      src_q <= '0;
      dst_q <= '0;
      len_q <= '0;
      i_q <= '0;
      tmp_q <= '0;
      aval_q <= '0;
      hrd_q <= '0;
      step_src_q <= 1'b0;
      inv_q <= 1'b0;
      csrc_q <= 1'b0;
      cin_q <= 1'b0;
      en_q <= 1'b0;
      cq_q <= 1'b0;
      rail_q <= 1'b1;
      skip_q <= 1'b0;
      edge_q <= '0;
      step_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      src_q <= src_d;
      dst_q <= dst_d;
      len_q <= len_d;
      i_q <= i_d;
      tmp_q <= tmp_d;
      aval_q <= aval_d;
      hrd_q <= hrd_d;
      step_src_q <= step_src_d;
      inv_q <= inv_d;
      csrc_q <= csrc_d;
      cin_q <= cin_d;
      en_q <= en_d;
      cq_q <= cq_d;
      rail_q <= rail_d;
      skip_q <= skip_d;
      edge_q <= edge_d;
      step_q <= step_d;
      done_q <= done_d;
      busy_q <= busy_d;
      end_q <= end_d;
    end
  end

  assign host_rdata = hrd_q;
  assign busy = busy_q;
  assign done = done_q;
  assign count_out = cq_q;
  assign rail_on = rail_q;
  assign skip_on = skip_q;
  assign end_hit = end_q;
  assign step_len = step_q;

  wire idle_go = start && state_q == ST_IDLE;

  counter_out_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    done_q && op_q == OP_EVENT_COUNTER_INSTR && en_q && $past(we)
    |-> count_out == ($past(wdata) >= aval_q))
    else $error("counter output disagrees with count and preset");
  counter_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_EVENT_COUNTER_INSTR && !skip_q
    |=> we && step_len == `STEPS_COUNTER ##1 done && !busy)
    else $error("counter did not update in one store cycle");
  rail_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_RAIL_GATE_OPEN && !skip_q && !rung_in
    ##2 (idle_go && op == OP_WORD_COPY)
    |=> done && !busy && !we)
    else $error("copy ran while the rail was gated off");
  skip_region_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_SKIP_REGION_BEGIN && !skip_q && rung_in && rail_on
    ##2 (idle_go && op == OP_WORD_COPY)
    |-> skip_on ##1 done && !busy && !we)
    else $error("skip region did not suppress execution");
  end_mark_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_PROGRAM_END
    |=> end_hit && done && step_len == `STEPS_ONE && !skip_on && rail_on)
    else $error("end instruction not recognised");
  word_copy_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_WORD_COPY && a_const && rung_in && rail_on && !skip_on
    |-> ##2 we && waddr == $past(opnd_b[AW-1:0], 2) &&
        wdata == $past(opnd_a, 2) ##1 done)
    else $error("word copy wrote wrong place or value");
  complement_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && op == OP_COMPLEMENT_COPY && a_const && rung_in && rail_on &&
    !skip_on |-> ##2 we && wdata == ~$past(opnd_a, 2))
    else $error("complement copy wrote wrong value");
  swap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == ST_STORE && op_q == OP_OPERAND_SWAP
    |=> state_q == ST_SWAP && we && waddr == src_q && wdata == $past(rd0))
    else $error("swap lost the destination's old value");
  index_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idle_go && (op == OP_INDEXED_READ || op == OP_INDEXED_WRITE) &&
    b_const && opnd_b >= DW'(table_len)
    |=> done && !busy && !we && step_len == `STEPS_INDEXED)
    else $error("out-of-range index made an access");
endmodule : ladder_transfer_control_exec
`default_nettype wire

// ==== verilog/reg_mem.sv ====
// Register memory: flip-flop words, two combinational reads, one write
`timescale 1ns/1ps
`default_nettype none
module reg_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr0,
  output logic [DW-1:0] rdata0,
  input wire logic [AW-1:0] raddr1,
  output logic [DW-1:0] rdata1
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] mem_d [2**AW];

  assign rdata0 = mem_q[raddr0];
  assign rdata1 = mem_q[raddr1];

  always_comb begin
    mem_d = mem_q;
    if (we) begin
      mem_d[waddr] = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 2**AW; k++) begin
        mem_q[k] <= '0;
      end
    end else begin
      mem_q <= mem_d;
    end
  end
endmodule : reg_mem
`default_nettype wire
